// *** rtl/apd_core.sv ***
// Result, peak-hold and display-value logic of the panel-meter converter
module apd_core
  import apd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire apd_regreq_t reg_req,
  input wire logic narrow_variant,
  input wire logic conv_valid,
  input wire logic [19:0] conv_raw,
  input wire logic battery_sense_input,
  output logic [15:0] rd_data_q,
  output logic rd_valid_q,
  output logic [15:0] display_value_q,
  output logic battery_low_flag_q,
  output logic batt_segment_on_q,
  output logic cal_every_conv_q,
  output logic enh_cal_start_q,
  output logic filter_en_q,
  output logic display_drv_en_q,
  output logic modulator_en_q,
  output logic input_buf_en_q
);

  // Peak view of a value; the narrow part ignores its four sub-bits
  function automatic logic signed [15:0] peak_view(
    input logic [15:0] v,
    input logic narrow
  );
    peak_view = narrow ? {v[15:4], APD_NIB_ZERO} : v;
  endfunction : peak_view

  apd_ctl_t ctl_q; // Control register
  logic [15:0] result_up_q; // Upper result word
  logic [7:0] result_lo_q; // Low nibble in upper half
  logic [15:0] peak_q; // Peak value
  logic peak_armed_q; // First result already copied
  logic [15:0] custom_ofs_q; // Signed custom offset
  logic res_new_q; // High in the cycle a new result lands
  logic [15:0] peak_d; // Next peak value
  logic peak_armed_d; // Next armed flag
  logic [15:0] display_d; // Next display value
  logic [19:0] result_diff; // Corrected 20-bit result
  logic ctl_wr; // Control register write
  logic disp_wr; // Display register write
  logic peak_clear; // Peak enable written low
  logic peak_mode; // Display follows the peak

  assign ctl_wr = reg_req.wr && (reg_req.sel == APD_SEL_CONTROL);
  assign disp_wr = reg_req.wr && (reg_req.sel == APD_SEL_DISPLAY);
  assign peak_clear = ctl_wr && !reg_req.data[APD_CTL_PEAK_EN];
  assign peak_mode = ctl_q.peak_en && !ctl_q.hold && !ctl_q.src_serial;

  // Offset is aligned with the upper word of the 20-bit result
  assign result_diff = conv_raw - {custom_ofs_q, APD_NIB_ZERO};

  // Control register; the trigger bit clears itself once issued
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctl_q <= APD_CTL_RST;
    end else if (ctl_wr) begin
      ctl_q <= apd_ctl_t'(reg_req.data[APD_CTL_W-1:0]);
    end else if (ctl_q.enhanced_offset_trigger) begin
      ctl_q.enhanced_offset_trigger <= 1'b0;
    end
  end

  // Custom offset register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      custom_ofs_q <= APD_WORD_RST;
    end else if (reg_req.wr && (reg_req.sel == APD_SEL_CUSTOM_OFS)) begin
      custom_ofs_q <= reg_req.data;
    end
  end

  // Result registers; the filter is stopped in digital powerdown
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      result_up_q <= APD_WORD_RST;
      result_lo_q <= APD_BYTE_RST;
      res_new_q <= 1'b0;
    end else begin
      res_new_q <= conv_valid && !ctl_q.digital_powerdown;
      if (conv_valid && !ctl_q.digital_powerdown) begin
        result_up_q <= result_diff[19:4];
        // Controller appends this nibble below the upper word
        result_lo_q <= {result_diff[3:0], APD_NIB_ZERO};
      end
    end
  end

  // Next peak; tracking is trusted only inside the valid count range
  always_comb begin
    peak_d = peak_q;
    peak_armed_d = peak_armed_q;
    if (peak_clear) begin
      peak_d = APD_WORD_RST;
      peak_armed_d = 1'b0;
    end else if (res_new_q && ctl_q.peak_en) begin
      if (!peak_armed_q) begin
        peak_d = result_up_q;
        peak_armed_d = 1'b1;
      end else if (peak_view(result_up_q, narrow_variant) >
                   peak_view(peak_q, narrow_variant)) begin
        peak_d = result_up_q;
      end else begin
        peak_d = peak_q;
      end
    end
  end

  // Peak register and its armed flag
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      peak_q <= APD_WORD_RST;
      peak_armed_q <= 1'b0;
    end else begin
      peak_q <= peak_d;
      peak_armed_q <= peak_armed_d;
    end
  end

  // Display source choice; hold freezes it against every source
  always_comb begin
    display_d = display_value_q;
    if (ctl_q.hold) begin
      display_d = display_value_q;
    end else if (ctl_q.src_serial) begin
      if (disp_wr) begin
        display_d = reg_req.data;
      end
    end else if (ctl_q.peak_en) begin
      display_d = peak_d;
    end else if (res_new_q) begin
      display_d = result_up_q;
    end
  end

  // Display value register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      display_value_q <= APD_WORD_RST;
    end else begin
      display_value_q <= display_d;
    end
  end

  // Battery status follows the comparator; segment tracks the flag
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      battery_low_flag_q <= 1'b0;
      batt_segment_on_q <= 1'b0;
    end else begin
      battery_low_flag_q <= battery_sense_input;
      batt_segment_on_q <= battery_sense_input;
    end
  end

  // Calibration and power controls to the analog side
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cal_every_conv_q <= 1'b1;
      enh_cal_start_q <= 1'b0;
      filter_en_q <= 1'b1;
      display_drv_en_q <= 1'b1;
      modulator_en_q <= 1'b1;
      input_buf_en_q <= 1'b1;
    end else begin
      cal_every_conv_q <= !ctl_q.auto_offset_control;
      enh_cal_start_q <= ctl_q.enhanced_offset_trigger;
      filter_en_q <= !ctl_q.digital_powerdown;
      display_drv_en_q <= !ctl_q.digital_powerdown;
      // Analog path ignores the digital bit entirely
      modulator_en_q <= !ctl_q.analog_powerdown;
      input_buf_en_q <= !ctl_q.analog_powerdown;
    end
  end

  // Read port; unknown selects read as zero, answer one cycle later
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data_q <= APD_WORD_RST;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= reg_req.rd;
      if (reg_req.rd) begin
        case (reg_req.sel)
          APD_SEL_RESULT_UP: rd_data_q <= result_up_q;
          APD_SEL_RESULT_LO: rd_data_q <= {8'h00, result_lo_q};
          APD_SEL_DISPLAY: rd_data_q <= display_value_q;
          APD_SEL_PEAK: rd_data_q <= peak_q;
          APD_SEL_CUSTOM_OFS: rd_data_q <= custom_ofs_q;
          APD_SEL_CONTROL: rd_data_q <= {9'h000, ctl_q};
          APD_SEL_STATUS: rd_data_q <= {15'h0000, battery_low_flag_q};
          default: rd_data_q <= APD_WORD_RST;
        endcase
      end
    end
  end

  // Checks on the behaviour above
  low_nib_zero_a: assert property (
    @(posedge core_clk) disable iff (rst)
    result_lo_q[3:0] == APD_NIB_ZERO)
    else $error("low nibble register lower bits not zero");

  result_calc_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (conv_valid && !ctl_q.digital_powerdown) |=>
      (result_up_q == $past(result_diff[19:4])) && res_new_q)
    else $error("result not calibrated input minus offset");

  peak_clear_a: assert property (
    @(posedge core_clk) disable iff (rst)
    peak_clear |=> (peak_q == APD_WORD_RST) && !peak_armed_q)
    else $error("peak not cleared by peak enable low");

  peak_grow_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (res_new_q && ctl_q.peak_en && !peak_clear && peak_armed_q &&
     ($signed(result_up_q) > $signed(peak_q)) && !narrow_variant) |=>
      peak_q == $past(result_up_q))
    else $error("larger result did not replace peak");

  peak_keep_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (res_new_q && peak_armed_q && !peak_clear &&
     ($signed(result_up_q) < $signed(peak_q))) |=> $stable(peak_q))
    else $error("smaller result changed peak");

  peak_display_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (peak_mode && $past(peak_mode)) |-> display_value_q == peak_q)
    else $error("peak mode display differs from peak");

  hold_freeze_a: assert property (
    @(posedge core_clk) disable iff (rst)
    ctl_q.hold |=> $stable(display_value_q))
    else $error("display changed while held");

  batt_flag_a: assert property (
    @(posedge core_clk) disable iff (rst)
    battery_sense_input |=> battery_low_flag_q && batt_segment_on_q)
    else $error("low battery not flagged");

  enh_pulse_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (ctl_wr && reg_req.data[APD_CTL_ENH_TRIG]) |=>
      ##1 enh_cal_start_q ##1 !enh_cal_start_q)
    else $error("enhanced calibration start not one pulse");

  power_down_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (ctl_wr && reg_req.data[APD_CTL_DIG_PD] &&
     !reg_req.data[APD_CTL_ANA_PD]) |=>
      ##1 !filter_en_q && !display_drv_en_q && modulator_en_q)
    else $error("digital powerdown wrong");

  auto_cal_a: assert property (
    @(posedge core_clk) disable iff (rst)
    !ctl_q.auto_offset_control |=> cal_every_conv_q)
    else $error("per conversion calibration not enabled");

  analog_down_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (ctl_wr && reg_req.data[APD_CTL_ANA_PD] &&
     !reg_req.data[APD_CTL_DIG_PD]) |=>
      ##1 !modulator_en_q && !input_buf_en_q && filter_en_q)
    else $error("analog powerdown wrong");

  // A result offered in digital powerdown must leave no trace at all
  pd_drop_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (conv_valid && ctl_q.digital_powerdown) |=>
      $stable(result_up_q) && !res_new_q)
    else $error("result taken during digital powerdown");

  serial_disp_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (disp_wr && ctl_q.src_serial && !ctl_q.hold) |=>
      display_value_q == $past(reg_req.data))
    else $error("serial write did not reach display");

  result_disp_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (res_new_q && !ctl_q.hold && !ctl_q.src_serial && !ctl_q.peak_en) |=>
      display_value_q == $past(result_up_q))
    else $error("display did not follow new result");

endmodule : apd_core

// *** rtl/apd_pkg.sv ***
// Package with register selects, field layouts and reset values
package apd_pkg;

  // Register select codes on the decoded serial register port
  localparam logic [3:0] APD_SEL_RESULT_UP = 4'h0;
  localparam logic [3:0] APD_SEL_RESULT_LO = 4'h1;
  localparam logic [3:0] APD_SEL_DISPLAY = 4'h2;
  localparam logic [3:0] APD_SEL_PEAK = 4'h3;
  localparam logic [3:0] APD_SEL_CUSTOM_OFS = 4'h4;
  localparam logic [3:0] APD_SEL_CONTROL = 4'h5;
  localparam logic [3:0] APD_SEL_STATUS = 4'h6;

  // Widths
  localparam int APD_WORD_W = 16;
  localparam int APD_RAW_W = 20;
  localparam int APD_NIB_W = 4;
  localparam int APD_CTL_W = 7;

  // Control field positions, low bit first
  localparam int APD_CTL_SRC_SERIAL = 0;
  localparam int APD_CTL_PEAK_EN = 1;
  localparam int APD_CTL_HOLD = 2;
  localparam int APD_CTL_AUTO_OFS = 3;
  localparam int APD_CTL_ENH_TRIG = 4;
  localparam int APD_CTL_DIG_PD = 5;
  localparam int APD_CTL_ANA_PD = 6;

  // Status field position
  localparam int APD_STAT_BATT_LOW = 0;

  // Reset values
  localparam logic [15:0] APD_WORD_RST = 16'h0000;
  localparam logic [7:0] APD_BYTE_RST = 8'h00;
  localparam logic [3:0] APD_NIB_ZERO = 4'h0;
  localparam logic [6:0] APD_CTL_RST = 7'h00;

  // Control register, same bit order as the positions above
  typedef struct packed {
    logic analog_powerdown;
    logic digital_powerdown;
    logic enhanced_offset_trigger;
    logic auto_offset_control;
    logic hold;
    logic peak_en;
    logic src_serial;
  } apd_ctl_t;

  // One register access from the serial interface
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] sel;
    logic [15:0] data;
  } apd_regreq_t;

endpackage : apd_pkg

// *** tb/apd_host_model.sv ***
// Controller-side model: register access tasks and result joining
module apd_host_model
  import apd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rd_valid_q,
  input wire logic [15:0] rd_data_q,
  output apd_regreq_t reg_req
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle port at time zero
  initial begin
    reg_req = '0;
  end

  // One write pulse; released data turns to its inverse so nothing stale
  task automatic write(input logic [3:0] s, input logic [15:0] v);
    @(posedge core_clk);
    reg_req <= '{1'b1, 1'b0, s, v};
    @(posedge core_clk);
    reg_req <= '{1'b0, 1'b0, s, ~v};
  endtask : write

  // One read pulse, then a bounded wait for the answer pulse
  task automatic read(input logic [3:0] s, output logic [15:0] v,
                      output logic ok);
    ok = 1'b0;
    v = '0;
    @(posedge core_clk);
    reg_req <= '{1'b0, 1'b1, s, 16'h0000};
    @(posedge core_clk);
    reg_req <= '{1'b0, 1'b0, s, 16'hFFFF};
    repeat (3) begin
      #1;
      // Valid stands one cycle only, so look every cycle
      if (!ok && rd_valid_q === 1'b1) begin
        ok = 1'b1;
        v = rd_data_q;
      end
      @(posedge core_clk);
    end
  endtask : read

  // Full result is the upper word followed by the top nibble of the byte
  function automatic logic [19:0] join_result(input logic [15:0] up,
                                              input logic [7:0] lo);
    return {up, lo[7:4]};
  endfunction : join_result
endmodule : apd_host_model

// *** tb/test_adc_result_peak_hold_display.sv ***
// Self-checking bench for the result, peak and display-value block
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module test_adc_result_peak_hold_display;
  import apd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic narrow_variant = 1'b0;
  logic conv_valid = 1'b0;
  logic [19:0] conv_raw = '0;
  logic battery_sense_input = 1'b0;
  apd_regreq_t reg_req;
  logic [15:0] rd_data_q, display_value_q, u, l;
  logic rd_valid_q, battery_low_flag_q, batt_segment_on_q, cal_every_conv_q;
  logic enh_cal_start_q, filter_en_q, display_drv_en_q, modulator_en_q;
  logic input_buf_en_q, k;
  int fails = 0;
  int total_checks = 0;
  int pulses;

  apd_core apd_core_i (.core_clk(core_clk), .rst(rst), .reg_req(reg_req),
    .narrow_variant(narrow_variant), .conv_valid(conv_valid),
    .conv_raw(conv_raw), .battery_sense_input(battery_sense_input),
    .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
    .display_value_q(display_value_q),
    .battery_low_flag_q(battery_low_flag_q),
    .batt_segment_on_q(batt_segment_on_q),
    .cal_every_conv_q(cal_every_conv_q), .enh_cal_start_q(enh_cal_start_q),
    .filter_en_q(filter_en_q), .display_drv_en_q(display_drv_en_q),
    .modulator_en_q(modulator_en_q), .input_buf_en_q(input_buf_en_q));
  apd_host_model host_i (.core_clk(core_clk), .rd_valid_q(rd_valid_q),
    .rd_data_q(rd_data_q), .reg_req(reg_req));

  // 200 MHz clock
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  // Read a register and compare; a missing answer pulse is a mismatch
  task automatic chk_rd(input string nm, input logic [3:0] s,
                        input logic [15:0] e);
    logic [15:0] v;
    logic ok;
    host_i.read(s, v, ok);
    `CHK(nm, 1'b1, ok)
    `CHK(nm, e, v)
  endtask : chk_rd

  // One conversion pulse, then let result, peak and display land
  task automatic conv(input logic [19:0] raw);
    @(posedge core_clk);
    conv_valid <= 1'b1;
    conv_raw <= raw;
    @(posedge core_clk);
    conv_valid <= 1'b0;
    conv_raw <= ~raw;
    settle();
  endtask : conv

  // A few edges so registered controls reach the outputs
  task automatic settle;
    repeat (3) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic print_verdict;
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    fails++;
    print_verdict();
  end

  // Main sequence; results stay inside the valid peak range
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    repeat (20) @(posedge core_clk);
    #1;
    `CHK("enables", 5'h1F, {cal_every_conv_q, filter_en_q, display_drv_en_q,
      modulator_en_q, input_buf_en_q})
    chk_rd("up_rst", APD_SEL_RESULT_UP, 16'h0000);
    chk_rd("lo_rst", APD_SEL_RESULT_LO, 16'h0000);
    chk_rd("disp_rst", APD_SEL_DISPLAY, 16'h0000);
    chk_rd("peak_rst", APD_SEL_PEAK, 16'h0000);
    host_i.write(APD_SEL_RESULT_UP, 16'hABCD);
    chk_rd("up_ro", APD_SEL_RESULT_UP, 16'h0000);
    host_i.write(APD_SEL_CUSTOM_OFS, 16'h0010);
    conv(20'h1_2345);
    host_i.read(APD_SEL_RESULT_UP, u, k);
    host_i.read(APD_SEL_RESULT_LO, l, k);
    `CHK("up", 16'h1224, u)
    `CHK("lo", 16'h0050, l)
    `CHK("full", 20'h1_2245, host_i.join_result(u, l[7:0]))
    `CHK("disp_res", 16'h1224, display_value_q)
    host_i.write(APD_SEL_CUSTOM_OFS, 16'h0000);
    host_i.write(APD_SEL_CONTROL, 16'h0002);
    conv(20'hF_F000);
    `CHK("peak_first", 16'hFF00, display_value_q)
    conv(20'h0_0500);
    conv(20'hF_FF00);
    `CHK("peak_disp", 16'h0050, display_value_q)
    chk_rd("peak_keep", APD_SEL_PEAK, 16'h0050);
    narrow_variant <= 1'b1;
    conv(20'h0_0580);
    conv(20'h0_05C0);
    // Sub-bits alone do not make a larger narrow reading
    chk_rd("peak_narrow", APD_SEL_PEAK, 16'h0050);
    conv(20'h0_0600);
    chk_rd("peak_narrow_up", APD_SEL_PEAK, 16'h0060);
    narrow_variant <= 1'b0;
    host_i.write(APD_SEL_CONTROL, 16'h0000);
    chk_rd("peak_clr", APD_SEL_PEAK, 16'h0000);
    conv(20'h0_0300);
    host_i.write(APD_SEL_CONTROL, 16'h0004);
    conv(20'h0_0700);
    host_i.write(APD_SEL_DISPLAY, 16'h5A5A);
    settle();
    `CHK("hold", 16'h0030, display_value_q)
    chk_rd("up_hold", APD_SEL_RESULT_UP, 16'h0070);
    host_i.write(APD_SEL_CONTROL, 16'h0001);
    host_i.write(APD_SEL_DISPLAY, 16'h1234);
    conv(20'h0_0900);
    chk_rd("disp_ser", APD_SEL_DISPLAY, 16'h1234);
    host_i.write(APD_SEL_CONTROL, 16'h0008);
    settle();
    `CHK("cal_every", 1'b0, cal_every_conv_q)
    host_i.write(APD_SEL_CONTROL, 16'h0020);
    conv(20'h0_0A00);
    `CHK("dig_pd", 4'h3, {filter_en_q, display_drv_en_q, modulator_en_q,
      input_buf_en_q})
    chk_rd("up_pd", APD_SEL_RESULT_UP, 16'h0090);
    host_i.write(APD_SEL_CONTROL, 16'h0040);
    settle();
    `CHK("ana_pd", 4'hC, {filter_en_q, display_drv_en_q, modulator_en_q,
      input_buf_en_q})
    host_i.write(APD_SEL_CONTROL, 16'h0010);
    pulses = 0;
    repeat (4) begin
      #1;
      if (enh_cal_start_q === 1'b1) pulses++;
      @(posedge core_clk);
    end
    `CHK("enh_pulse", 1, pulses)
    chk_rd("ctl_clr", APD_SEL_CONTROL, 16'h0000);
    battery_sense_input <= 1'b1;
    settle();
    `CHK("batt_on", 2'b11, {battery_low_flag_q, batt_segment_on_q})
    chk_rd("status", APD_SEL_STATUS, 16'h0001);
    battery_sense_input <= 1'b0;
    settle();
    `CHK("batt_off", 2'b00, {battery_low_flag_q, batt_segment_on_q})
    print_verdict();
  end
endmodule : test_adc_result_peak_hold_display
